// >>> hw/dtr_engine.sv
// Debug engine control for trace, return, breakpoint gating and debug registers
// Notes on behaviour
// RULE1: Trace: busy status, pop return address, restore interrupt enable, fetch it.
// RULE2: After the one instruction, stall CPU, block next fetch, push return address.
// RULE3: Re-entry: save and clear partition bit, pointer 8010h, clear enable, halt, idle.
// RULE4: Pointer advances each step, so pushed address is the next instruction.
// RULE5: Trace refused in system memory when several memory regions are defined.
// RULE6: Return: pop, restore partition bit and enable, resume, nondebug status.
// RULE7: First instruction after return never breaks.
// RULE8: Leaving debug re-enables suspended timer functions.
// RULE9: With switchback enable, debug entry forces divide-by-1 clock.
// RULE10: External reset pin resets engine to background, even from stop mode.
// RULE11: During trace the global interrupt enable keeps the captured entry value.
// RULE12: Pending interrupt may be granted during a trace step.
// RULE13: Traced stop with interrupts enabled still wakes on enabled interrupts.
// RULE14: Debug entry needs one stack slot; full stack overwrites oldest entry.
// RULE15: In debug all counters off except warm-up; its completion switches clock. Here timers also run during the trace step.
// RULE16: System clock stopped between debug commands inside active debug.
// RULE17: Host clocks the test port at most one eighth of system clock.
// RULE18: Temp registers accessible only in background or debug; reset to zero.
// RULE19: Control bit 7 gates breakpoints; changes only from background mode.
// RULE20: Register select bit 5: break 4 on destination address match, gate needed.
// RULE21: Break 5 on destination address and masked data match with debug data.
// RULE22: Command field reflects host command for ROM; other codes reserved.
`timescale 1ns/100ps
module dtr_engine
    import dtr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        tlr_i,
    input  wire logic        ext_reset_i,
    input  wire dtr_wb_req_t wb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire dtr_hcmd_t   hcmd_i,
    input  wire logic        bp_match_i,
    input  wire logic        bg_mode_i,
    input  wire logic        instr_done_i,
    input  wire logic        in_sys_mem_i,
    input  wire logic        multi_region_i,
    input  wire logic [15:0] ip_i,
    input  wire logic [15:0] stack_top_i,
    input  wire logic        global_irq_enable_i,
    input  wire logic        memory_partition_bit_i,
    input  wire logic        power_manage_divide_i,
    input  wire logic        warmup_done_i,
    input  wire logic        dst_write_i,
    input  wire logic [15:0] dst_addr_i,
    input  wire logic [15:0] dst_data_i,
    input  wire logic [15:0] register_address_break_i,
    input  wire logic [15:0] register_pattern_break_i,
    input  wire logic [15:0] debug_match_data_reg_i,
    input  wire logic [15:0] debug_mask_address_reg_i,
    output logic [1:0]       status_o,
    output dtr_stack_t       stack_o,
    output logic             fetch_en_o,
    output logic             cpu_stall_o,
    output logic             ip_load_o,
    output logic [15:0]      ip_load_val_o,
    output logic             global_irq_enable_o,
    output logic             irq_override_o,
    output logic             memory_partition_bit_o,
    output logic             partition_load_o,
    output logic             force_divide_one_o,
    output logic             timers_run_o,
    output logic             sysclk_run_o,
    output logic             clk_switch_o,
    output logic             break_o,
    output logic             trace_refused_o
);

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    dtr_state_t  state;
    logic [15:0] debug_temp_zero;
    logic [15:0] debug_temp_one;
    logic [7:0]  debug_control;
    logic        saved_irq_en;
    logic        saved_partition;
    logic        skip_first;
    logic        eng_rst;
    logic        in_debug;
    logic        wb_hit;
    logic        reg_break;
    logic        any_break;

    // Engine reset sources
    // RULE10: pin resets engine
    assign eng_rst  = rst_i | tlr_i | ext_reset_i;
    assign in_debug = (state != DTR_BACKGROUND);
    assign wb_hit   = wb_i.cyc & wb_i.stb & ~wb_ack_o;

    // ------------------------------------------------------------
    // Breakpoint qualification
    // ------------------------------------------------------------
    // RULE20: address break
    // RULE21: pattern break
    always_comb
    begin
        reg_break = 1'b0;
        if (debug_control[CTRL_REGSEL_BIT] && dst_write_i)
        begin
            reg_break = (dst_addr_i == register_address_break_i) |
                        ((dst_addr_i == register_pattern_break_i) &
                         dtr_masked_eq(dst_data_i, debug_match_data_reg_i,
                                       debug_mask_address_reg_i));
        end
    end

    // RULE19: gate all breaks
    // RULE7: skip first instruction
    assign any_break = debug_control[CTRL_GATE_BIT] & ~in_debug & ~skip_first &
                       (bp_match_i | reg_break);

    // ------------------------------------------------------------
    // Trace and return sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (eng_rst)
        begin
            state <= DTR_BACKGROUND;
        end
        else
        begin
            unique case (state)
                DTR_BACKGROUND:
                    if (any_break || (hcmd_i.valid && hcmd_i.kind == DTR_HOST_SVC))
                        state <= DTR_IDLE;
                DTR_IDLE:
                    if (hcmd_i.valid && hcmd_i.kind == DTR_HOST_TRACE &&
                        !(in_sys_mem_i && multi_region_i))
                        // RULE5: refuse system trace
                        state <= DTR_TR_POP;
                    else if (hcmd_i.valid && hcmd_i.kind == DTR_HOST_RETURN)
                        state <= DTR_RET_POP;
                DTR_TR_POP:
                    state <= DTR_TR_EXEC;
                DTR_TR_EXEC:
                    // RULE2: stall after one
                    if (instr_done_i)
                        state <= DTR_TR_PUSH;
                DTR_TR_PUSH:
                    state <= DTR_IDLE;
                DTR_RET_POP:
                    state <= DTR_RET_GO;
                DTR_RET_GO:
                    state <= DTR_BACKGROUND;
            endcase
        end
    end

    // Capture entry state of enable and partition bit
    always_ff @(posedge clk_i)
    begin
        if (eng_rst)
        begin
            saved_irq_en    <= 1'b0;
            saved_partition <= 1'b0;
        end
        else if (state == DTR_BACKGROUND && !any_break &&
                 !(hcmd_i.valid && hcmd_i.kind == DTR_HOST_SVC))
        begin
            saved_irq_en    <= global_irq_enable_i;
        end
        else if (state == DTR_TR_PUSH || (state == DTR_BACKGROUND))
        begin
            // RULE3: save partition bit
            saved_partition <= memory_partition_bit_i;
        end
    end

    // First instruction after return carries no break
    always_ff @(posedge clk_i)
    begin
        if (eng_rst)
            skip_first <= 1'b0;
        else if (state == DTR_RET_GO)
            skip_first <= 1'b1;
        else if (instr_done_i)
            skip_first <= 1'b0;
    end

    // Trace refusal flag, one cycle
    always_ff @(posedge clk_i)
    begin
        if (eng_rst)
            trace_refused_o <= 1'b0;
        else
            trace_refused_o <= (state == DTR_IDLE) & hcmd_i.valid &
                               (hcmd_i.kind == DTR_HOST_TRACE) &
                               in_sys_mem_i & multi_region_i;
    end

    // ------------------------------------------------------------
    // Outputs toward the CPU
    // ------------------------------------------------------------
    always_comb
    begin
        status_o = ST_NONDEBUG;
        unique case (state)
            DTR_BACKGROUND: status_o = ST_NONDEBUG;
            // RULE3: idle status
            DTR_IDLE:       status_o = ST_IDLE;
            // RULE1: busy status
            default:        status_o = ST_BUSY;
        endcase
    end

    // RULE1: pop for trace
    // RULE6: pop for return
    // RULE14: push overwrites oldest
    // RULE4: push next address
    always_comb
    begin
        stack_o.pop  = (state == DTR_TR_POP) | (state == DTR_RET_POP);
        stack_o.push = (state == DTR_TR_PUSH) | ((state == DTR_BACKGROUND) & any_break);
        stack_o.data = ip_i;
    end

    // Fetch path: from return address during trace, blocked after
    // RULE2: block next fetch
    assign fetch_en_o    = (state == DTR_BACKGROUND) | (state == DTR_TR_EXEC);
    assign cpu_stall_o   = (state != DTR_BACKGROUND) & (state != DTR_TR_EXEC);
    // RULE3: vector load
    assign ip_load_o     = (state == DTR_TR_POP) | (state == DTR_RET_POP) |
                           (state == DTR_TR_PUSH) | ((state == DTR_BACKGROUND) & any_break);
    assign ip_load_val_o = ((state == DTR_TR_POP) | (state == DTR_RET_POP)) ?
                           stack_top_i : DEBUG_VECTOR;

    // RULE11: keep captured enable
    // RULE12: enable during step
    // RULE13: stop wake allowed
    assign global_irq_enable_o = (state == DTR_TR_EXEC) | (state == DTR_RET_GO) ?
                                 saved_irq_en : 1'b0;
    assign irq_override_o      = in_debug;

    // RULE6: restore partition bit
    assign partition_load_o       = (state == DTR_TR_PUSH) | (state == DTR_RET_GO);
    assign memory_partition_bit_o = (state == DTR_RET_GO) ? saved_partition : 1'b0;

    // RULE9: switchback to divide-by-1
    assign force_divide_one_o = debug_control[CTRL_SWB_BIT] & power_manage_divide_i &
                                (in_debug | any_break);
    // RULE8: timers re-enabled
    // RULE15: counters off in debug except during trace step
    assign timers_run_o = ~in_debug | (state == DTR_TR_EXEC);
    assign clk_switch_o = in_debug & warmup_done_i;
    // RULE16: clock stop between commands
    assign sysclk_run_o = ~(state == DTR_IDLE) | hcmd_i.valid;
    assign break_o      = any_break;

    // ------------------------------------------------------------
    // Register file over Wishbone
    // ------------------------------------------------------------
    // RULE18: temp access gated
    always_ff @(posedge clk_i)
    begin
        if (rst_i | tlr_i)
        begin
            debug_temp_zero <= TEMP_RESET;
            debug_temp_one  <= TEMP_RESET;
        end
        else if (wb_hit && wb_i.we && (bg_mode_i || in_debug))
        begin
            if (wb_i.adr == ADDR_TEMP_ZERO && wb_i.sel[0])
                debug_temp_zero[7:0]  <= wb_i.dat[7:0];
            if (wb_i.adr == ADDR_TEMP_ZERO && wb_i.sel[1])
                debug_temp_zero[15:8] <= wb_i.dat[15:8];
            if (wb_i.adr == ADDR_TEMP_ONE && wb_i.sel[0])
                debug_temp_one[7:0]   <= wb_i.dat[7:0];
            if (wb_i.adr == ADDR_TEMP_ONE && wb_i.sel[1])
                debug_temp_one[15:8]  <= wb_i.dat[15:8];
        end
    end

    // Control bits; command field set by engine only
    // RULE19: change only in background
    // RULE22: reflect command code
    always_ff @(posedge clk_i)
    begin
        if (rst_i | tlr_i)
            debug_control <= CTRL_RESET;
        else
        begin
            if (wb_hit && wb_i.we && wb_i.adr == ADDR_CONTROL && wb_i.sel[0] && bg_mode_i)
                debug_control[7:4] <= wb_i.dat[7:4];
            if (hcmd_i.valid && hcmd_i.kind == DTR_HOST_SVC && dtr_code_ok(hcmd_i.code))
                debug_control[3:0] <= hcmd_i.code;
            else if (state == DTR_RET_GO)
                debug_control[3:0] <= CMD_NONE;
        end
    end

    // Single-wait ack and read data
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h0000_0000;
            if (wb_hit && !wb_i.we)
            begin
                unique case (wb_i.adr)
                    ADDR_TEMP_ZERO: wb_dat_o <= (bg_mode_i | in_debug) ?
                                                {16'h0000, debug_temp_zero} : 32'h0000_0000;
                    ADDR_TEMP_ONE:  wb_dat_o <= (bg_mode_i | in_debug) ?
                                                {16'h0000, debug_temp_one} : 32'h0000_0000;
                    ADDR_CONTROL:   wb_dat_o <= {24'h00_0000, debug_control};
                    ADDR_CMD:       wb_dat_o <= {29'h0000_0000, state};
                    default:        wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // dtr_engine

// >>> hw/dtr_pkg.sv
// Package of constants and types for the debug trace and return control block
package dtr_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the Wishbone slave)
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_TEMP_ZERO  = 4'h0;
    localparam logic [3:0]  ADDR_TEMP_ONE   = 4'h4;
    localparam logic [3:0]  ADDR_CONTROL    = 4'h8;
    localparam logic [3:0]  ADDR_CMD        = 4'hc;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          CTRL_GATE_BIT   = 7;
    localparam int          CTRL_REGSEL_BIT = 5;
    localparam int          CTRL_SWB_BIT    = 4;
    localparam logic [15:0] TEMP_RESET      = 16'h0000;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [15:0] DEBUG_VECTOR    = 16'h8010;

    // Debug status codes
    localparam logic [1:0]  ST_NONDEBUG     = 2'h0;
    localparam logic [1:0]  ST_IDLE         = 2'h1;
    localparam logic [1:0]  ST_BUSY         = 2'h2;
    localparam logic [1:0]  ST_VALID        = 2'h3;

    // Command codes reflected to ROM code
    localparam logic [3:0]  CMD_NONE        = 4'h0;
    localparam logic [3:0]  CMD_REG_MAP     = 4'h1;
    localparam logic [3:0]  CMD_DATA_READ   = 4'h2;
    localparam logic [3:0]  CMD_STACK_READ  = 4'h3;
    localparam logic [3:0]  CMD_REG_WRITE   = 4'h4;
    localparam logic [3:0]  CMD_DATA_WRITE  = 4'h5;
    localparam logic [3:0]  CMD_UNLOCK      = 4'h8;
    localparam logic [3:0]  CMD_REG_READ    = 4'h9;

    // Host command kinds
    typedef enum logic [1:0] {
        DTR_HOST_NONE   = 2'b00,
        DTR_HOST_SVC    = 2'b01,
        DTR_HOST_TRACE  = 2'b10,
        DTR_HOST_RETURN = 2'b11
    } dtr_host_t;

    // Engine states
    typedef enum logic [2:0] {
        DTR_BACKGROUND  = 3'b000,
        DTR_IDLE        = 3'b001,
        DTR_TR_POP      = 3'b010,
        DTR_TR_EXEC     = 3'b011,
        DTR_TR_PUSH     = 3'b100,
        DTR_RET_POP     = 3'b101,
        DTR_RET_GO      = 3'b110
    } dtr_state_t;

    // Host command carrier
    typedef struct packed {
        logic       valid;
        dtr_host_t  kind;
        logic [3:0] code;
    } dtr_hcmd_t;

    // Stack request carrier toward the CPU
    typedef struct packed {
        logic        push;
        logic        pop;
        logic [15:0] data;
    } dtr_stack_t;

    // Wishbone request carrier
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [3:0]  adr;
        logic [31:0] dat;
    } dtr_wb_req_t;

    // Command code must be a documented one
    function automatic logic dtr_code_ok(input logic [3:0] c);
        return (c <= CMD_DATA_WRITE) || (c == CMD_UNLOCK) || (c == CMD_REG_READ);
    endfunction

    // Masked pattern compare
    function automatic logic dtr_masked_eq(input logic [15:0] a, input logic [15:0] b,
                                           input logic [15:0] m);
        return ((a ^ b) & m) == 16'h0000;
    endfunction

endpackage

// >>> test/dtr_engine_sva.sv
// Port checker for the debug trace and return engine
`timescale 1ns/100ps
module dtr_engine_sva
    import dtr_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        tlr_i,
    input wire logic        ext_reset_i,
    input wire dtr_hcmd_t   hcmd_i,
    input wire logic        in_sys_mem_i,
    input wire logic        multi_region_i,
    input wire logic [15:0] stack_top_i,
    input wire logic [1:0]  status_o,
    input wire dtr_stack_t  stack_o,
    input wire logic        ip_load_o,
    input wire logic [15:0] ip_load_val_o,
    input wire logic        global_irq_enable_o,
    input wire logic        memory_partition_bit_o,
    input wire logic        partition_load_o,
    input wire logic        timers_run_o,
    input wire logic        sysclk_run_o,
    input wire logic        break_o,
    input wire logic        trace_refused_o
);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || tlr_i || ext_reset_i);

    sequence s_pop_return;
        stack_o.pop && ip_load_o && ip_load_val_o == stack_top_i;
    endsequence
    sequence s_trace_exec;
        status_o == ST_BUSY && !stack_o.pop && !stack_o.push;
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_trace_start: assert property (
        hcmd_i.valid && hcmd_i.kind == DTR_HOST_TRACE && status_o == ST_IDLE
        && !(in_sys_mem_i && multi_region_i)
        |=> s_pop_return and status_o == ST_BUSY ##1 s_trace_exec)
        else $error("trace start walk broken");
    a_trace_refuse: assert property (
        hcmd_i.valid && hcmd_i.kind == DTR_HOST_TRACE && status_o == ST_IDLE
        && in_sys_mem_i && multi_region_i |=> trace_refused_o && status_o == ST_IDLE)
        else $error("trace not refused");
    a_reentry_load: assert property (
        stack_o.push && status_o == ST_BUSY |-> ip_load_o && ip_load_val_o == DEBUG_VECTOR
        && partition_load_o && !memory_partition_bit_o && !global_irq_enable_o
        ##1 status_o == ST_IDLE)
        else $error("trace reentry wrong");
    a_irq_hold: assert property (
        s_trace_exec ##1 s_trace_exec |-> $stable(global_irq_enable_o))
        else $error("irq enable changed in step");
    a_return_walk: assert property (
        hcmd_i.valid && hcmd_i.kind == DTR_HOST_RETURN && status_o == ST_IDLE
        |=> s_pop_return ##1 partition_load_o ##1 status_o == ST_NONDEBUG)
        else $error("return walk broken");
    a_no_first_break: assert property (
        status_o == ST_NONDEBUG && $past(status_o) != ST_NONDEBUG |-> !break_o)
        else $error("break right after return");
    a_idle_clock: assert property (
        status_o == ST_IDLE && !hcmd_i.valid |-> !sysclk_run_o)
        else $error("system clock runs in idle");
    a_bg_timers: assert property (
        status_o == ST_NONDEBUG |-> timers_run_o)
        else $error("timers off in background");
endmodule // dtr_engine_sva

bind dtr_engine dtr_engine_sva dtr_engine_sva_inst (.*);

// >>> test/dtr_engine_tb_top.sv
// Self-checking bench for the debug trace and return engine
`timescale 1ns/100ps
module dtr_engine_tb_top
    import dtr_pkg::*;
;
    logic        clk_i = 1'b0, rst_i = 1'b1, tlr = 1'b0, xrst = 1'b0, bg = 1'b0;
    logic        bp = 1'b0, done = 1'b0, sysm = 1'b0, multi = 1'b0, irq = 1'b0;
    logic        memory_partition_bit = 1'b0, power_manage_divide = 1'b0, warm = 1'b0, dw = 1'b0, hreq = 1'b0;
    logic [15:0] ip = '0, top = '0, dadr = '0, ddat = '0, bp4 = '0, bp5 = '0;
    logic [15:0] ipv;
    logic [3:0]  hcode = '0, gap = '0;
    logic [31:0] q, r, dat;
    logic [1:0]  st;
    logic        ipl, gie, upo, upl, fdo, trun, srun, brk, tref, ack;
    dtr_host_t   hkind = DTR_HOST_NONE;
    dtr_hcmd_t   hcmd;
    dtr_stack_t  stk;
    dtr_wb_req_t wb = '0;
    wire [6:0]   ev = {st == ST_NONDEBUG, tref, brk, upl, stk.push, stk.pop, st == ST_IDLE};
    int          err_total = 0, samples_checked = 0, n = 0;
    logic [3:0]  codes [8] = '{CMD_NONE, CMD_REG_MAP, CMD_DATA_READ, CMD_STACK_READ,
                               CMD_REG_WRITE, CMD_DATA_WRITE, CMD_UNLOCK, CMD_REG_READ};

    always #5 clk_i = ~clk_i;

    dtr_host_model dtr_host_model_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(hreq),
        .kind_i(hkind), .code_i(hcode), .gap_i(gap), .hcmd_o(hcmd));
    dtr_engine dtr_engine_inst (.clk_i(clk_i), .rst_i(rst_i), .tlr_i(tlr), .ext_reset_i(xrst),
        .wb_i(wb), .wb_dat_o(dat), .wb_ack_o(ack), .hcmd_i(hcmd), .bp_match_i(bp),
        .bg_mode_i(bg), .instr_done_i(done), .in_sys_mem_i(sysm), .multi_region_i(multi),
        .ip_i(ip), .stack_top_i(top), .global_irq_enable_i(irq), .memory_partition_bit_i(memory_partition_bit),
        .power_manage_divide_i(power_manage_divide), .warmup_done_i(warm), .dst_write_i(dw),
        .dst_addr_i(dadr), .dst_data_i(ddat), .register_address_break_i(bp4),
        .register_pattern_break_i(bp5), .debug_match_data_reg_i(16'h0000),
        .debug_mask_address_reg_i(16'h0000), .status_o(st), .stack_o(stk), .fetch_en_o(),
        .cpu_stall_o(), .ip_load_o(ipl), .ip_load_val_o(ipv), .global_irq_enable_o(gie),
        .irq_override_o(), .memory_partition_bit_o(upo), .partition_load_o(upl),
        .force_divide_one_o(fdo), .timers_run_o(trun), .sysclk_run_o(srun),
        .clk_switch_o(), .break_o(brk), .trace_refused_o(tref));

    // ------------------------------------------------------------
    // Checking, bus and host tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        if (err_total == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tmo(input bit ok);
        n = 0;
        if (!ok)
        begin
            err_total++;
            end_sim();
        end
    endtask
    task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [31:0] d);
        @(posedge clk_i);
        wb <= {1'b1, 1'b1, we, 4'hf, adr, d};
        do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
        tmo(n < 20);
        q = dat;
        wb <= '0;
    endtask
    task automatic rd(input logic [3:0] adr, input logic [31:0] e);
        wb_cycle(1'b0, adr, 32'h0);
        chk(q, e);
    endtask
    task automatic host(input dtr_host_t k, input logic [3:0] c);
        @(posedge clk_i);
        hreq  <= 1'b1;
        hkind <= k;
        hcode <= c;
        gap   <= 4'($urandom);
        @(posedge clk_i);
        hreq  <= 1'b0;
    endtask
    task automatic wt(input int b, input int k);
        do @(negedge clk_i); while (ev[b] !== 1'b1 && ++n < k);
        tmo(n < k);
    endtask
    task automatic wait_idle;
        wt(0, 60);
        @(posedge clk_i);
    endtask
    task automatic ret(input logic u);
        @(posedge clk_i);
        top <= 16'($urandom);
        host(DTR_HOST_RETURN, CMD_NONE);
        wt(1, 60);
        chk(ipv, top);
        wt(3, 9);
        chk(upo, u);
        wt(6, 9);
        chk(trun, 1'b1);
        chk(brk, 1'b0);
        @(posedge clk_i);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'ha83b));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADDR_TEMP_ZERO, 32'h0);
        rd(ADDR_CONTROL, {24'h0, CTRL_RESET});
        rd(4'h2, 32'h0);
        r = $urandom;
        wb_cycle(1'b1, ADDR_TEMP_ONE, r);
        rd(ADDR_TEMP_ONE, 32'h0);
        wb_cycle(1'b1, ADDR_CONTROL, 32'hb5);
        rd(ADDR_CONTROL, 32'h0);
        bg <= 1'b1;
        wb_cycle(1'b1, ADDR_TEMP_ONE, r);
        rd(ADDR_TEMP_ONE, {16'h0, r[15:0]});
        wb_cycle(1'b1, ADDR_CONTROL, 32'hb5);
        rd(ADDR_CONTROL, 32'hb0);
        // Every command code shows in the field
        power_manage_divide <= 1'b1;
        foreach (codes[i])
        begin
            memory_partition_bit <= codes[i][0];
            host(DTR_HOST_SVC, codes[i]);
            wait_idle();
            chk(fdo, 1'b1);
            chk(srun, 1'b0);
            rd(ADDR_CONTROL, {24'h0, 4'hb, codes[i]});
            ret(codes[i][0]);
        end
        // Single steps keep the entry enable
        repeat (3)
        begin
            irq <= 1'b1;
            memory_partition_bit <= 1'b1;
            host(DTR_HOST_SVC, CMD_NONE);
            wait_idle();
            irq <= 1'b0;
            top <= 16'($urandom);
            host(DTR_HOST_TRACE, CMD_NONE);
            wt(1, 60);
            chk(ipv, top);
            chk(st, ST_BUSY);
            @(posedge clk_i);
            ip <= top + 16'h0001;
            @(negedge clk_i);
            chk(gie, 1'b1);
            @(posedge clk_i);
            done <= 1'b1;
            @(posedge clk_i);
            done <= 1'b0;
            wt(2, 9);
            chk(stk.data, ip);
            chk(ipv, DEBUG_VECTOR);
            chk(upo, 1'b0);
            ret(1'b1);
        end
        // Step refused in system code
        host(DTR_HOST_SVC, CMD_NONE);
        wait_idle();
        sysm  <= 1'b1;
        multi <= 1'b1;
        host(DTR_HOST_TRACE, CMD_NONE);
        wt(5, 60);
        chk(st, ST_IDLE);
        ret(1'b1);
        sysm <= 1'b0;
        // Gated breakpoint, quiet first cycle, reset pin exit
        bp   <= 1'b1;
        done <= 1'b1;
        @(negedge clk_i);
        chk(brk, 1'b0);
        @(posedge clk_i);
        done <= 1'b0;
        wait_idle();
        bp   <= 1'b0;
        xrst <= 1'b1;
        @(posedge clk_i);
        xrst <= 1'b0;
        @(negedge clk_i);
        chk(st, ST_NONDEBUG);
        // Register address break
        @(posedge clk_i);
        r = $urandom;
        {power_manage_divide, warm} <= r[1:0];
        bp4  <= r[15:0];
        bp5  <= ~r[15:0];
        dadr <= r[15:0];
        ddat <= r[31:16];
        dw   <= 1'b1;
        wt(4, 9);
        @(posedge clk_i);
        dw <= 1'b0;
        wait_idle();
        chk(fdo, r[1]);
        ret(1'b1);
        // Cleared gate blocks every break
        wb_cycle(1'b1, ADDR_CONTROL, 32'h00);
        bp <= 1'b1;
        dw <= 1'b1;
        done <= 1'b1;
        repeat (4) @(negedge clk_i);
        chk(st, ST_NONDEBUG);
        @(posedge clk_i);
        tlr <= 1'b1;
        @(posedge clk_i);
        tlr <= 1'b0;
        rd(ADDR_TEMP_ONE, 32'h0);
        end_sim();
    end
endmodule // dtr_engine_tb_top

// >>> test/dtr_host_model.sv
// Debug host model issuing paced commands to the engine
`timescale 1ns/100ps
module dtr_host_model
    import dtr_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       req_i,
    input  wire dtr_host_t  kind_i,
    input  wire logic [3:0] code_i,
    input  wire logic [3:0] gap_i,
    output dtr_hcmd_t       hcmd_o
);
    // ------------------------------------------------------------
    // Request latch and paced issue
    // ------------------------------------------------------------
    logic       pend;
    dtr_host_t  pkind;
    logic [3:0] pcode;
    logic [3:0] gap;

    // Holds one bench request until it may go out
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (pend && gap == 4'h0))
            pend <= 1'b0;
        else if (req_i)
            pend <= 1'b1;
        if (req_i)
        begin
            pkind <= kind_i;
            pcode <= code_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hcmd_o <= '0;
            gap    <= 4'h0;
        end
        else if (pend && gap == 4'h0)
        begin
            hcmd_o <= {1'b1, pkind, pcode};
            gap    <= 4'h8 | gap_i;
        end
        else
        begin
            hcmd_o <= {1'b0, ~hcmd_o.kind, ~hcmd_o.code}; // Stale fields scrambled
            gap    <= gap - {3'h0, gap != 4'h0};
        end
    end
endmodule // dtr_host_model
